/* verilog/hub_port_params.svh */
// Constants of the hub port power, overcurrent and suspend control block
//
// Summary of operation
// - Per-port mode: each of four overcurrent inputs is judged independently.
// - Overcurrent inputs are active low and noise filtered against short spikes.
// - Four power-enable outputs always driven; low means port power on.
// - Reset initializes all logic; system asserts it at power-up.
// - Suspend indicator high while suspended, low in normal operation.
// - Clock mode select is captured after reset and only reported as a status bit; no clocks are derived here.
// - With serial memory disabled, shared pin picks ganged mode; pin stays static.
`ifndef HUB_PORT_PARAMS_SVH
`define HUB_PORT_PARAMS_SVH

// ----------------------------------------------------------------
// Timing
// ----------------------------------------------------------------
`define CLK_PERIOD_NS 8
`define OC_FILTER_NS 200
`define OC_FILTER_CYCLES ((`OC_FILTER_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define OC_CNT_W 5

// ----------------------------------------------------------------
// Register map (byte addresses)
// ----------------------------------------------------------------
`define REG_ADDR_W 4
`define ADDR_CTRL 4'h0
`define ADDR_STATUS 4'h4
`define ADDR_INT_STAT 4'h8
`define ADDR_INT_MASK 4'hc

// ----------------------------------------------------------------
// Field positions and reset values
// ----------------------------------------------------------------
`define NUM_PORTS 4
`define CTRL_SUSPEND_BIT 4
`define STAT_OC_LSB 0
`define STAT_PWR_LSB 4
`define STAT_GANGED_BIT 8
`define STAT_FASTCLK_BIT 9
`define STAT_SUSPEND_BIT 10
`define CTRL_RESET 5'h00
`define INT_MASK_RESET 4'h0

`endif

/* verilog/hub_port_pkg.sv */
// Types shared by the hub port control block
`default_nettype none
package hub_port_pkg;
  // One-hot phases of mode capture after reset
  typedef enum logic [1:0] {
    ST_STRAP = 2'b01,
    ST_RUN = 2'b10
  } strap_state_t;
endpackage
`default_nettype wire

/* verilog/oc_filter.sv */
// Noise filter for one active-low overcurrent input
`include "hub_port_params.svh"
`default_nettype none
module oc_filter (
  input wire logic sys_clk_i,
  input wire logic sys_rst_i,
  input wire logic oc_raw_n_i,
  output logic oc_o
);
  localparam int FLT = `OC_FILTER_CYCLES;
  localparam logic [`OC_CNT_W-1:0] CNT_LAST = `OC_CNT_W'(`OC_FILTER_CYCLES - 1);
  localparam logic [`OC_CNT_W-1:0] CNT_FULL = `OC_CNT_W'(`OC_FILTER_CYCLES);

  logic [`OC_CNT_W-1:0] cnt_ff;
  logic oc_ff;

  // ----------------------------------------------------------------
  // Level must differ from the filtered state for a full window
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk_i) begin
    if (sys_rst_i) begin
      cnt_ff <= '0;
    end else if ((~oc_raw_n_i) == oc_ff) begin
      cnt_ff <= '0; // Spike ended: restart window
    end else if (cnt_ff == CNT_LAST) begin
      cnt_ff <= '0;
    end else begin
      cnt_ff <= cnt_ff + `OC_CNT_W'(1);
    end
  end

  // Filtered level flips only when the window completes
  always_ff @(posedge sys_clk_i) begin
    if (sys_rst_i) begin
      oc_ff <= 1'b0;
    end else if ((~oc_raw_n_i) != oc_ff && cnt_ff == CNT_LAST) begin
      oc_ff <= ~oc_raw_n_i; // Low input means overcurrent
    end
  end

  assign oc_o = oc_ff;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  a_spike_rejected:
    assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
      $rose(oc_ff) |-> $past(~oc_raw_n_i, FLT))
    else $error("overcurrent accepted without a full filter window");

  // Run of consecutive low samples, counted apart from the filter itself
  logic [`OC_CNT_W-1:0] low_run_ff;

  always_ff @(posedge sys_clk_i) begin
    if (sys_rst_i || oc_raw_n_i) begin
      low_run_ff <= '0;
    end else if (low_run_ff != CNT_FULL) begin
      low_run_ff <= low_run_ff + `OC_CNT_W'(1); // Saturates at a full window
    end
  end

  a_filter_delay:
    assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
      (low_run_ff == CNT_FULL) |-> ##[0:1] oc_ff)
    else $error("filtered overcurrent late");
endmodule // oc_filter
`default_nettype wire

/* verilog/hub_port_ctrl.sv */
// Hub downstream port power, overcurrent, suspend and clock mode control with AHB-Lite registers
`include "hub_port_params.svh"
`default_nettype none
module hub_port_ctrl (
  input wire logic sys_clk_i,
  input wire logic sys_rst_i,
  // AHB-Lite slave
  input wire logic hsel_i,
  input wire logic [31:0] haddr_i,
  input wire logic [1:0] htrans_i,
  input wire logic hwrite_i,
  input wire logic [2:0] hsize_i,
  input wire logic [31:0] hwdata_i,
  input wire logic hready_i,
  output logic [31:0] hrdata_o,
  output logic hreadyout_o,
  output logic hresp_o,
  // Port pins
  input wire logic port1_overcurrent_n_i,
  input wire logic port2_overcurrent_n_i,
  input wire logic port3_overcurrent_n_i,
  input wire logic port4_overcurrent_n_i,
  output logic port1_power_enable_n_o,
  output logic port2_power_enable_n_o,
  output logic port3_power_enable_n_o,
  output logic port4_power_enable_n_o,
  output logic suspend_indicator_o,
  // Straps and interrupt output
  input wire logic serial_mem_disable_i,
  input wire logic serial_mem_data_or_shared_power_mode_i,
  input wire logic clock_mode_select_i,
  output logic irq_o
);
  localparam int NP = `NUM_PORTS;

  hub_port_pkg::strap_state_t state_ff;
  logic ganged_ff;
  logic fast_clk_ff;
  logic [`CTRL_SUSPEND_BIT:0] ctrl_ff;
  logic [NP-1:0] int_stat_ff;
  logic [NP-1:0] int_mask_ff;
  logic [NP-1:0] oc_flt;
  logic [NP-1:0] oc_raw_n;
  logic [NP-1:0] oc_eff;
  logic [NP-1:0] oc_eff_prev_ff;
  logic [NP-1:0] oc_rise;
  logic [NP-1:0] pwr_n_ff;
  logic [NP-1:0] nxt_pwr_n;
  logic suspend_ff;
  logic irq_ff;
  logic [31:0] hrdata_ff;
  logic wr_pend_ff;
  logic [`REG_ADDR_W-1:0] wr_addr_ff;
  logic addr_phase;

  // Spread one bit to all ports
  function automatic logic [NP-1:0] spread(input logic b);
    spread = {NP{b}};
  endfunction

  // ----------------------------------------------------------------
  // Overcurrent filtering
  // ----------------------------------------------------------------
  assign oc_raw_n = {port4_overcurrent_n_i, port3_overcurrent_n_i, port2_overcurrent_n_i, port1_overcurrent_n_i};

  // One independent filter per port
  for (genvar i = 0; i < NP; i++) begin : g_flt
    oc_filter u_flt (
      .sys_clk_i(sys_clk_i),
      .sys_rst_i(sys_rst_i),
      .oc_raw_n_i(oc_raw_n[i]),
      .oc_o(oc_flt[i])
    );
  end

  // Ganged pins are tied together, so any one stands for all
  always_comb begin
    oc_eff = ganged_ff ? spread(|oc_flt) : oc_flt;
    oc_rise = oc_eff & ~oc_eff_prev_ff;
  end

  always_ff @(posedge sys_clk_i) begin
    if (sys_rst_i) begin
      oc_eff_prev_ff <= '0;
    end else begin
      oc_eff_prev_ff <= oc_eff;
    end
  end

  // ----------------------------------------------------------------
  // Strap capture after reset release
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk_i) begin
    if (sys_rst_i) begin
      state_ff <= hub_port_pkg::ST_STRAP;
      ganged_ff <= 1'b0;
      fast_clk_ff <= 1'b0;
    end else begin
      case (state_ff)
        hub_port_pkg::ST_STRAP: begin
          ganged_ff <= serial_mem_disable_i & serial_mem_data_or_shared_power_mode_i;
          fast_clk_ff <= clock_mode_select_i;
          state_ff <= hub_port_pkg::ST_RUN;
        end
        hub_port_pkg::ST_RUN: begin
          state_ff <= hub_port_pkg::ST_RUN;
        end
        default: begin
          state_ff <= hub_port_pkg::ST_STRAP;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // AHB-Lite slave, zero wait states
  // ----------------------------------------------------------------
  assign addr_phase = hsel_i & htrans_i[1] & hready_i;

  // Register read data at the address phase so it stands in the data phase
  always_ff @(posedge sys_clk_i) begin
    if (sys_rst_i) begin
      hrdata_ff <= '0;
    end else if (addr_phase && !hwrite_i && haddr_i[31:`REG_ADDR_W] == '0) begin
      case (haddr_i[`REG_ADDR_W-1:0])
        `ADDR_CTRL: hrdata_ff <= 32'(ctrl_ff);
        `ADDR_STATUS: hrdata_ff <= 32'({suspend_ff, fast_clk_ff, ganged_ff, ~pwr_n_ff, oc_eff});
        `ADDR_INT_STAT: hrdata_ff <= 32'(int_stat_ff);
        `ADDR_INT_MASK: hrdata_ff <= 32'(int_mask_ff);
        default: hrdata_ff <= '0;
      endcase
    end else begin
      hrdata_ff <= '0;
    end
  end

  // Remember a write until its data phase
  always_ff @(posedge sys_clk_i) begin
    if (sys_rst_i) begin
      wr_pend_ff <= 1'b0;
      wr_addr_ff <= '0;
    end else begin
      wr_pend_ff <= addr_phase & hwrite_i & (haddr_i[31:`REG_ADDR_W] == '0);
      wr_addr_ff <= haddr_i[`REG_ADDR_W-1:0];
    end
  end

  // Never stalls and always answers OKAY, in reset as well
  always_ff @(posedge sys_clk_i) begin
    hreadyout_o <= 1'b1;
    hresp_o <= 1'b0;
  end

  assign hrdata_o = hrdata_ff;

  // ----------------------------------------------------------------
  // Control register; overcurrent drops the power request
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk_i) begin
    if (sys_rst_i) begin
      ctrl_ff <= `CTRL_RESET;
    end else begin
      if (wr_pend_ff && wr_addr_ff == `ADDR_CTRL) begin
        ctrl_ff <= hwdata_i[`CTRL_SUSPEND_BIT:0];
      end
      if (|oc_rise) begin
        ctrl_ff[NP-1:0] <= ganged_ff ? '0
          : (wr_pend_ff && wr_addr_ff == `ADDR_CTRL ? hwdata_i[NP-1:0] : ctrl_ff[NP-1:0]) & ~oc_rise;
      end
    end
  end

  // ----------------------------------------------------------------
  // Power enables, push-pull, low means on
  // ----------------------------------------------------------------
  always_comb begin
    if (state_ff != hub_port_pkg::ST_RUN) begin
      nxt_pwr_n = '1;
    end else if (ganged_ff) begin
      nxt_pwr_n = ~(spread(ctrl_ff[0]) & ~oc_eff);
    end else begin
      nxt_pwr_n = ~(ctrl_ff[NP-1:0] & ~oc_eff);
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (sys_rst_i) begin
      pwr_n_ff <= '1;
    end else begin
      pwr_n_ff <= nxt_pwr_n;
    end
  end

  assign port1_power_enable_n_o = pwr_n_ff[0];
  assign port2_power_enable_n_o = pwr_n_ff[1];
  assign port3_power_enable_n_o = pwr_n_ff[2];
  assign port4_power_enable_n_o = pwr_n_ff[3];

  // Suspend indicator follows the suspend request
  always_ff @(posedge sys_clk_i) begin
    if (sys_rst_i) begin
      suspend_ff <= 1'b0;
    end else begin
      suspend_ff <= ctrl_ff[`CTRL_SUSPEND_BIT];
    end
  end

  assign suspend_indicator_o = suspend_ff;

  // ----------------------------------------------------------------
  // Interrupts: sticky status, write one to clear, set wins
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk_i) begin
    if (sys_rst_i) begin
      int_stat_ff <= '0;
      int_mask_ff <= `INT_MASK_RESET;
    end else begin
      if (wr_pend_ff && wr_addr_ff == `ADDR_INT_MASK) begin
        int_mask_ff <= hwdata_i[NP-1:0];
      end
      if (wr_pend_ff && wr_addr_ff == `ADDR_INT_STAT) begin
        int_stat_ff <= (int_stat_ff & ~hwdata_i[NP-1:0]) | oc_rise;
      end else begin
        int_stat_ff <= int_stat_ff | oc_rise;
      end
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (sys_rst_i) begin
      irq_ff <= 1'b0;
    end else begin
      irq_ff <= |(int_stat_ff & int_mask_ff);
    end
  end

  assign irq_o = irq_ff;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  sequence s_oc_seen(int p);
    oc_flt[p] && !ganged_ff && state_ff == hub_port_pkg::ST_RUN;
  endsequence

  sequence s_port_off(int p);
    ##1 pwr_n_ff[p];
  endsequence

  a_port_oc_off:
    assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
      s_oc_seen(2) |-> s_port_off(2))
    else $error("per-port overcurrent did not switch its port off");

  a_port_isolation:
    assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
      (state_ff == hub_port_pkg::ST_RUN && !ganged_ff && oc_flt[0] && !oc_flt[1] && ctrl_ff[1])
      |=> !pwr_n_ff[1])
    else $error("per-port overcurrent affected another port");

  a_gang_all_off:
    assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
      (ganged_ff && |oc_flt) |=> (pwr_n_ff == '1))
    else $error("ganged overcurrent left a port powered");

  a_gang_together:
    assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
      ganged_ff |-> (pwr_n_ff == '0 || pwr_n_ff == '1))
    else $error("ganged ports not switched together");

  a_drive_known:
    assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
      (state_ff == hub_port_pkg::ST_RUN && !ganged_ff && ctrl_ff[3] && !oc_eff[3]) |=> !pwr_n_ff[3])
    else $error("requested port power not driven low");

  a_reset_init:
    assert property (@(posedge sys_clk_i)
      sys_rst_i |=> (pwr_n_ff == '1 && !suspend_ff && int_stat_ff == '0 && state_ff == hub_port_pkg::ST_STRAP))
    else $error("reset did not initialize the block");

  a_suspend_follow:
    assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
      ##1 suspend_ff == $past(ctrl_ff[`CTRL_SUSPEND_BIT]))
    else $error("suspend indicator does not follow suspend state");

  a_strap_stable:
    assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
      (state_ff == hub_port_pkg::ST_RUN) |=> $stable(ganged_ff) && $stable(fast_clk_ff))
    else $error("mode straps changed during operation");

  a_clk_mode_cap:
    assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
      (state_ff == hub_port_pkg::ST_STRAP) |=> fast_clk_ff == $past(clock_mode_select_i))
    else $error("clock source mode not captured");
endmodule // hub_port_ctrl
`default_nettype wire

/* dv/port_switch_model.sv */
// Model of one external port power switch with its overcurrent sensor
`default_nettype none
module port_switch_model (
  input wire logic power_enable_n_i,
  input wire logic fault_i,
  output logic overcurrent_n_o
);
  timeunit 1ns;
  timeprecision 1ps;
  // ----------------------------------------------------------------
  // Sensor
  // ----------------------------------------------------------------
  // A load fault shows only while the switch is on; low enable means on
  assign overcurrent_n_o = !(fault_i && !power_enable_n_i);
endmodule // port_switch_model
`default_nettype wire

/* dv/tb.sv */
// Self-checking testbench of the hub port control block
`include "hub_port_params.svh"
`default_nettype none
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  typedef struct {
    logic [31:0] ctrl;
    logic [4:0] pins;
    logic [31:0] status;
  } row_t;
  logic sys_clk_i = 1'b0;
  logic sys_rst_i = 1'b1;
  logic hsel = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [2:0] hsize = 3'h2;
  logic [31:0] hwdata = 32'h0;
  logic [31:0] hrdata;
  logic hreadyout;
  logic hresp;
  logic [3:0] pe_n;
  logic [3:0] oc_m;
  logic [3:0] oc_n;
  logic [3:0] fault = 4'h0;
  logic ganged = 1'b0;
  logic mem_dis = 1'b1;
  logic clk_mode = 1'b0;
  logic suspend;
  logic irq;
  logic [31:0] rd;
  int n_fail = 0;
  int comparisons = 0;
  row_t rows [4] = '{'{32'h01, 5'h0e, 32'h010}, '{32'h05, 5'h0a, 32'h050},
                     '{32'h10, 5'h1f, 32'h400}, '{32'h0f, 5'h00, 32'h0f0}};
  // ----------------------------------------------------------------
  // Clock, design and far side
  // ----------------------------------------------------------------
  // Clock running through reset as well
  initial begin
    forever #4 sys_clk_i = ~sys_clk_i;
  end
  // Ganged boards tie all overcurrent lines together
  assign oc_n = ganged ? {4{&oc_m}} : oc_m;
  for (genvar k = 0; k < 4; k++) begin : g_sw
    port_switch_model u_sw (.power_enable_n_i(pe_n[k]), .fault_i(fault[k]), .overcurrent_n_o(oc_m[k]));
  end
  hub_port_ctrl u_dut (.sys_clk_i(sys_clk_i), .sys_rst_i(sys_rst_i), .hsel_i(hsel), .haddr_i(haddr),
    .htrans_i(htrans), .hwrite_i(hwrite), .hsize_i(hsize), .hwdata_i(hwdata), .hready_i(hreadyout),
    .hrdata_o(hrdata), .hreadyout_o(hreadyout), .hresp_o(hresp),
    .port1_overcurrent_n_i(oc_n[0]), .port2_overcurrent_n_i(oc_n[1]), .port3_overcurrent_n_i(oc_n[2]),
    .port4_overcurrent_n_i(oc_n[3]), .port1_power_enable_n_o(pe_n[0]), .port2_power_enable_n_o(pe_n[1]),
    .port3_power_enable_n_o(pe_n[2]), .port4_power_enable_n_o(pe_n[3]), .suspend_indicator_o(suspend),
    .serial_mem_disable_i(mem_dis), .serial_mem_data_or_shared_power_mode_i(ganged),
    .clock_mode_select_i(clk_mode), .irq_o(irq));
  // ----------------------------------------------------------------
  // Tasks
  // ----------------------------------------------------------------
  // Verdict and end of run
  task automatic wrap_up();
    $display("Comparisons %0d, mismatches %0d", comparisons, n_fail);
    if (n_fail == 0 && comparisons > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  // Compare seen against expected
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      n_fail++;
      $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  // Wait for hready high under a bound
  task automatic wait_ready();
    int i;
    for (i = 0; i < 50; i++) begin
      @(posedge sys_clk_i);
      if (hreadyout === 1'b1) break;
    end
    if (i == 50) begin
      n_fail++;
      wrap_up();
    end
  endtask
  // One single AHB-Lite word transfer
  task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] wd, output logic [31:0] r);
    @(posedge sys_clk_i);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= {28'h0, a};
    hwrite <= w;
    wait_ready();
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    wait_ready();
    r = hrdata;
    check({31'h0, hresp}, 32'h0);
  endtask
  // Reset pulse, also used in mid-run
  task automatic do_reset();
    sys_rst_i <= 1'b1;
    repeat (4) @(posedge sys_clk_i);
    check({27'h0, suspend, pe_n}, 32'h0f);
    sys_rst_i <= 1'b0;
  endtask
  // Let a number of cycles pass
  task automatic idle(input int n);
    repeat (n) @(posedge sys_clk_i);
  endtask
  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  // Reset, register table, then faults, spikes, masking and ganged mode
  initial begin
    do_reset();
    foreach (rows[i]) begin
      bus(1'b0, `ADDR_CTRL + 4'(4 * i), 32'h0, rd);
      check(rd, 32'h0);
    end
    bus(1'b0, 4'h0, 32'h0, rd);
    check({31'h0, irq}, 32'h0);
    foreach (rows[i]) begin
      bus(1'b1, `ADDR_CTRL, rows[i].ctrl, rd);
      idle(3);
      check({27'h0, suspend, pe_n}, {27'h0, rows[i].pins});
      bus(1'b0, `ADDR_STATUS, 32'h0, rd);
      check(rd, rows[i].status);
    end
    fault <= 4'h2;
    idle(20);
    fault <= 4'h0;
    idle(10);
    check({28'h0, pe_n}, 32'h0);
    bus(1'b0, `ADDR_INT_STAT, 32'h0, rd);
    check(rd, 32'h0);
    bus(1'b1, `ADDR_INT_MASK, 32'h4, rd);
    fault <= 4'h4;
    idle(30);
    check({28'h0, pe_n}, 32'h4);
    check({31'h0, irq}, 32'h1);
    bus(1'b0, `ADDR_INT_STAT, 32'h0, rd);
    check(rd, 32'h4);
    bus(1'b0, `ADDR_CTRL, 32'h0, rd);
    check(rd, 32'h0b);
    fault <= 4'h0;
    bus(1'b1, `ADDR_INT_STAT, 32'h4, rd);
    idle(30);
    check({31'h0, irq}, 32'h0);
    bus(1'b1, `ADDR_CTRL, 32'h0f, rd);
    fault <= 4'h1;
    idle(30);
    check({28'h0, pe_n}, 32'h1);
    check({31'h0, irq}, 32'h0);
    bus(1'b0, `ADDR_INT_STAT, 32'h0, rd);
    check(rd, 32'h1);
    fault <= 4'h0;
    ganged <= 1'b1;
    clk_mode <= 1'b1;
    do_reset();
    bus(1'b0, `ADDR_STATUS, 32'h0, rd);
    check(rd, 32'h300);
    bus(1'b1, `ADDR_CTRL, 32'h01, rd);
    idle(3);
    check({28'h0, pe_n}, 32'h0);
    fault <= 4'h8;
    idle(30);
    check({28'h0, pe_n}, 32'h0f);
    bus(1'b0, `ADDR_INT_STAT, 32'h0, rd);
    check(rd, 32'h0f);
    fault <= 4'h0;
    mem_dis <= 1'b0;
    do_reset();
    bus(1'b0, `ADDR_STATUS, 32'h0, rd);
    check(rd, 32'h200);
    wrap_up();
  end
endmodule // tb
`default_nettype wire
